// file: pkg/dpfm_pkg.sv
// Purpose: Shared constants and types of the drive protection fault monitor.
// Assumes: 50 MHz core clock; register offsets are byte addresses of 32-bit words.
// Notes: Times held in registers are counted in milliseconds of the tick base.
package dpfm_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PROT = 8'h04;
  localparam logic [7:0] OFS_TEMPTHR = 8'h08;
  localparam logic [7:0] OFS_OVSPD = 8'h0c;
  localparam logic [7:0] OFS_SPDTOL = 8'h10;
  localparam logic [7:0] OFS_SPDTIME = 8'h14;
  localparam logic [7:0] OFS_POSTOL = 8'h18;
  localparam logic [7:0] OFS_POSTIME = 8'h1c;
  localparam logic [7:0] OFS_IPEAK = 8'h20;
  localparam logic [7:0] OFS_ICONT = 8'h24;
  localparam logic [7:0] OFS_PEAKTIME = 8'h28;
  localparam logic [7:0] OFS_ENCRES = 8'h2c;
  localparam logic [7:0] OFS_ESTEP = 8'h30;
  localparam logic [7:0] OFS_BRKMAX = 8'h34;
  localparam logic [7:0] OFS_FAULT = 8'h38;
  localparam logic [7:0] OFS_STATUS = 8'h3c;

  ////////////////////////////////////////////////////////////////////////////
  // Protection enable field positions and codes.
  localparam int PR_HALL = 0;
  localparam int PR_ENC = 1;
  localparam int PR_IDX = 2;
  localparam int PR_MTEMP = 3;
  localparam int PR_OVSPD = 4;
  localparam int PR_CTRL = 5;
  localparam int PR_MTYPE = 6;
  localparam int PR_TMODE = 8;
  localparam logic [1:0] MT_BRUSHLESS = 2'h0;
  localparam logic [1:0] MT_LAST = 2'h2;
  localparam logic [2:0] TM_THRESH = 3'h0;
  localparam logic [2:0] TM_NEG = 3'h1;
  localparam logic [2:0] TM_POS = 3'h2;
  localparam logic [2:0] TM_SW_NO = 3'h3;
  localparam logic [2:0] TM_SW_NC = 3'h4;

  // Fault flag positions.
  localparam int FB_CFG = 0;
  localparam int FB_HALL = 1;
  localparam int FB_ENC = 2;
  localparam int FB_IDX = 3;
  localparam int FB_MTEMP = 4;
  localparam int FB_OVSPD = 5;
  localparam int FB_SPD = 6;
  localparam int FB_POS = 7;
  localparam int FB_BRAKE = 8;
  localparam int FB_BUSOV = 9;
  localparam int FB_BUSUV = 10;
  localparam int FB_DRVOT = 11;

  // Pin vector positions.
  localparam int PIN_ENCA = 3;
  localparam int PIN_ENCB = 4;
  localparam int PIN_IDX = 5;
  localparam int PIN_TSW = 6;
  localparam int PIN_BRK = 7;
  localparam int PIN_BUSOV = 8;
  localparam int PIN_BUSUV = 9;
  localparam int PIN_DRVOT = 10;

  localparam logic [15:0] IPEAK_RST = 16'h0000;
  localparam logic [15:0] ICONT_RST = 16'h0000;

  typedef struct packed {
    logic [10:0] s1;
    logic [10:0] s2;
    logic [10:0] s3;
    logic [10:0] filt;
    logic [10:0] prevFilt;
    logic run;
    logic [10:0] prot;
    logic [15:0] tempThr;
    logic [31:0] ovLim;
    logic [31:0] spdTol;
    logic [15:0] spdTime;
    logic [31:0] posTol;
    logic [15:0] posTime;
    logic [15:0] iPeak;
    logic [15:0] iCont;
    logic [15:0] peakTime;
    logic [31:0] encRes;
    logic [15:0] eStep;
    logic [15:0] brkMax;
    logic [11:0] faults;
    logic [31:0] tickCnt;
    logic [15:0] angle;
    logic synced;
    logic [31:0] idxCnt;
    logic idxArmed;
    logic [15:0] spdCnt;
    logic [15:0] posCnt;
    logic [15:0] brkCnt;
    logic [47:0] i2tAcc;
    logic restricted;
    logic motorEn;
    logic faultOut;
    logic [15:0] curLimit;
    logic [31:0] rdata;
  } dpfm_state_t;

endpackage

// file: logic/dpfm_monitor.sv
// Purpose: Fault-protection monitor of a motor drive with a plain register port.
// Assumes: Pins pass three flip-flops; analog values arrive digitised on core_clk.
// Notes: Fault flags are sticky and cleared by writing ones to the fault register.
// Operation
// - Any enabled protection tripping disables motor output and records its cause.
// - Out-of-range settings or config writes while enabled raise configuration fault.
// - Hall check flags invalid states, all-high, all-low, or illegal transitions.
// - Hall-based checks are off for brushed and stepper motor types.
// - Encoder-derived sector must be within one sector of the hall sector on brushless motors.
// - At each index pulse after the first, the encoder count magnitude must equal the resolution.
// - Custom threshold: positive trips above, negative trips below the reading.
// - Switch sensor trips when normally-open closes or normally-closed opens.
// - Negative mode trips below and positive mode above the threshold register, compared directly with the reading.
// - Overspeed trips when speed magnitude in either direction exceeds limit.
// - Speed and position tracking checks need the control-error enable.
// - Speed error beyond tolerance for longer than speed time trips.
// - Zero speed tolerance disables the speed tracking check.
// - Position error beyond tolerance for longer than position time trips.
// - Zero position tolerance disables the position tracking check.
// - Current-squared-time limiter is always active with no enable.
// - Current above continuous allowed up to peak only for peak time.
// - Peak and continuous limits are clamped to the drive ratings.
// - Brake resistor on longer than permitted raises overpower fault.
// - Bus voltage above maximum or below minimum raises bus faults.
// - Internal temperature above maximum raises drive over-temperature fault.
`timescale 1ns/1ps
module dpfm_monitor #(
  parameter int unsigned TICK_CYCLES = dpfm_pkg::TICK_CYCLES,
  parameter logic [15:0] DRIVE_PEAK = 16'h0400,
  parameter logic [15:0] DRIVE_CONT = 16'h0100
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic [2:0] hallIn,
  input wire logic encA,
  input wire logic encB,
  input wire logic encIndex,
  input wire logic tempSwitch,
  input wire logic brakeOn,
  input wire logic busOverV,
  input wire logic busUnderV,
  input wire logic driveOverTemp,
  input wire logic [11:0] tempAdc,
  input wire logic [31:0] speedAct,
  input wire logic [31:0] speedCmd,
  input wire logic [31:0] posAct,
  input wire logic [31:0] posCmd,
  input wire logic [15:0] currentMag,
  output logic motorEnable,
  output logic faultActive,
  output logic [15:0] currentLimit,
  output logic i2tRestricted
);

  dpfm_pkg::dpfm_state_t st_reg;
  dpfm_pkg::dpfm_state_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.
  function automatic logic [31:0] absVal(input logic [31:0] v);
    return v[31] ? 32'(-v) : v;
  endfunction

  function automatic logic [2:0] hallSector(input logic [2:0] h);
    case (h)
      3'h1: return 3'h0;
      3'h3: return 3'h1;
      3'h2: return 3'h2;
      3'h6: return 3'h3;
      3'h4: return 3'h4;
      default: return 3'h5;
    endcase
  endfunction

  // Sectors equal or one apart, modulo six.
  function automatic logic sectorNear(input logic [2:0] a, input logic [2:0] b);
    logic [2:0] d;
    d = (a >= b) ? 3'(a - b) : 3'(b - a);
    return (d <= 3'h1) || (d == 3'h5);
  endfunction

  function automatic logic [15:0] sectorStart(input logic [2:0] k);
    case (k)
      3'h0: return 16'h0000;
      3'h1: return 16'h2aab;
      3'h2: return 16'h5555;
      3'h3: return 16'h8000;
      3'h4: return 16'haaab;
      default: return 16'hd555;
    endcase
  endfunction

  // Millisecond counter that runs while a condition holds and saturates.
  function automatic logic [15:0] msCount(input logic act, input logic tick, input logic [15:0] c);
    if (!act) begin
      return 16'h0000;
    end
    if (tick && c != 16'hffff) begin
      return 16'(c + 16'h0001);
    end
    return c;
  endfunction

  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    logic tick;
    logic [11:0] flt;
    logic [11:0] clr;
    logic [2:0] hall;
    logic [2:0] hallPrev;
    logic hallOk;
    logic hallMoved;
    logic bldc;
    logic a;
    logic b;
    logic pa;
    logic pb;
    logic moved;
    logic up;
    logic [18:0] prod;
    logic [15:0] thrMag;
    logic [2:0] tmode;
    logic ot;
    logic spdAct;
    logic posAct_;
    logic brkAct;
    logic [15:0] pk;
    logic [15:0] ct;
    logic [31:0] sq;
    logic [31:0] c2;
    logic [47:0] budget;
    logic cfgWr;
    logic badVal;
    tick = 1'b0;
    flt = '0;
    clr = '0;
    hall = '0;
    hallPrev = '0;
    hallOk = 1'b0;
    hallMoved = 1'b0;
    bldc = 1'b0;
    a = 1'b0;
    b = 1'b0;
    pa = 1'b0;
    pb = 1'b0;
    moved = 1'b0;
    up = 1'b0;
    prod = '0;
    thrMag = '0;
    tmode = '0;
    ot = 1'b0;
    spdAct = 1'b0;
    posAct_ = 1'b0;
    brkAct = 1'b0;
    pk = '0;
    ct = '0;
    sq = '0;
    c2 = '0;
    budget = '0;
    cfgWr = 1'b0;
    badVal = 1'b0;
    st_next = st_reg;

    // Millisecond time base.
    tick = (st_reg.tickCnt == 32'(TICK_CYCLES - 1));
    st_next.tickCnt = tick ? 32'h0000_0000 : 32'(st_reg.tickCnt + 32'h0000_0001);

    // Pin synchronisers; a level is taken once stages two and three agree.
    st_next.s1 = {driveOverTemp, busUnderV, busOverV, brakeOn, tempSwitch, encIndex, encB, encA, hallIn};
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.filt = (st_reg.s2 & ~(st_reg.s2 ^ st_reg.s3)) | (st_reg.filt & (st_reg.s2 ^ st_reg.s3));
    st_next.prevFilt = st_reg.filt;

    bldc = (st_reg.prot[dpfm_pkg::PR_MTYPE +: 2] == dpfm_pkg::MT_BRUSHLESS);

    // Hall state and transition check.
    hall = st_reg.filt[2:0];
    hallPrev = st_reg.prevFilt[2:0];
    hallOk = (hall != 3'h0) && (hall != 3'h7);
    hallMoved = (hall != hallPrev);
    if (st_reg.prot[dpfm_pkg::PR_HALL] && bldc) begin
      if (!hallOk) begin
        flt[dpfm_pkg::FB_HALL] = 1'b1;
      end else if (hallMoved && hallPrev != 3'h0 && hallPrev != 3'h7 &&
                   !sectorNear(hallSector(hall), hallSector(hallPrev))) begin
        flt[dpfm_pkg::FB_HALL] = 1'b1;
      end
    end

    // Quadrature decode; a double-bit change is dropped as noise.
    a = st_reg.filt[dpfm_pkg::PIN_ENCA];
    b = st_reg.filt[dpfm_pkg::PIN_ENCB];
    pa = st_reg.prevFilt[dpfm_pkg::PIN_ENCA];
    pb = st_reg.prevFilt[dpfm_pkg::PIN_ENCB];
    moved = (a ^ pa) ^ (b ^ pb);
    up = pa ^ b;
    if (moved) begin
      st_next.angle = up ? 16'(st_reg.angle + st_reg.eStep) : 16'(st_reg.angle - st_reg.eStep);
      st_next.idxCnt = up ? 32'(st_reg.idxCnt + 32'h0000_0001) : 32'(st_reg.idxCnt - 32'h0000_0001);
    end

    // Encoder against hall sector; the angle re-aligns at every hall edge into a valid state.
    prod = 19'(st_reg.angle) * 19'h0_0006;
    if (hallMoved && hallOk) begin
      if (st_reg.prot[dpfm_pkg::PR_ENC] && bldc && st_reg.synced &&
          !sectorNear(prod[18:16], hallSector(hall))) begin
        flt[dpfm_pkg::FB_ENC] = 1'b1;
      end
      st_next.angle = sectorStart(hallSector(hall));
      st_next.synced = 1'b1;
    end

    // Index pulse: compare counts since the previous index.
    if (st_reg.filt[dpfm_pkg::PIN_IDX] && !st_reg.prevFilt[dpfm_pkg::PIN_IDX]) begin
      if (st_reg.prot[dpfm_pkg::PR_IDX] && st_reg.idxArmed && absVal(st_next.idxCnt) != st_reg.encRes) begin
        flt[dpfm_pkg::FB_IDX] = 1'b1;
      end
      st_next.idxCnt = 32'h0000_0000;
      st_next.idxArmed = 1'b1;
    end

    // Motor temperature by sensor mode.
    tmode = st_reg.prot[dpfm_pkg::PR_TMODE +: 3];
    thrMag = st_reg.tempThr[15] ? 16'(-st_reg.tempThr) : st_reg.tempThr;
    case (tmode)
      dpfm_pkg::TM_THRESH: ot = st_reg.tempThr[15] ? (16'(tempAdc) < thrMag) : (16'(tempAdc) > thrMag);
      dpfm_pkg::TM_NEG: ot = 16'(tempAdc) < st_reg.tempThr;
      dpfm_pkg::TM_POS: ot = 16'(tempAdc) > st_reg.tempThr;
      dpfm_pkg::TM_SW_NO: ot = st_reg.filt[dpfm_pkg::PIN_TSW];
      dpfm_pkg::TM_SW_NC: ot = !st_reg.filt[dpfm_pkg::PIN_TSW];
      default: ot = 1'b0;
    endcase
    if (st_reg.prot[dpfm_pkg::PR_MTEMP] && ot) begin
      flt[dpfm_pkg::FB_MTEMP] = 1'b1;
    end

    if (st_reg.prot[dpfm_pkg::PR_OVSPD] && absVal(speedAct) > st_reg.ovLim) begin
      flt[dpfm_pkg::FB_OVSPD] = 1'b1;
    end

    // Tracking errors over time windows.
    spdAct = st_reg.prot[dpfm_pkg::PR_CTRL] && st_reg.spdTol != 32'h0000_0000 &&
             absVal(32'(speedAct - speedCmd)) > st_reg.spdTol;
    posAct_ = st_reg.prot[dpfm_pkg::PR_CTRL] && st_reg.posTol != 32'h0000_0000 &&
              absVal(32'(posAct - posCmd)) > st_reg.posTol;
    st_next.spdCnt = msCount(spdAct, tick, st_reg.spdCnt);
    st_next.posCnt = msCount(posAct_, tick, st_reg.posCnt);
    if (spdAct && st_reg.spdCnt > st_reg.spdTime) begin
      flt[dpfm_pkg::FB_SPD] = 1'b1;
    end
    if (posAct_ && st_reg.posCnt > st_reg.posTime) begin
      flt[dpfm_pkg::FB_POS] = 1'b1;
    end

    // Brake resistor on-time.
    brkAct = st_reg.filt[dpfm_pkg::PIN_BRK];
    st_next.brkCnt = msCount(brkAct, tick, st_reg.brkCnt);
    if (brkAct && st_reg.brkCnt > st_reg.brkMax) begin
      flt[dpfm_pkg::FB_BRAKE] = 1'b1;
    end

    flt[dpfm_pkg::FB_BUSOV] = st_reg.filt[dpfm_pkg::PIN_BUSOV];
    flt[dpfm_pkg::FB_BUSUV] = st_reg.filt[dpfm_pkg::PIN_BUSUV];
    flt[dpfm_pkg::FB_DRVOT] = st_reg.filt[dpfm_pkg::PIN_DRVOT];

    // Current-squared-time limiter, always running.
    pk = min16(st_reg.iPeak, DRIVE_PEAK);
    ct = min16(min16(st_reg.iCont, DRIVE_CONT), pk);
    sq = 32'(currentMag) * 32'(currentMag);
    c2 = 32'(ct) * 32'(ct);
    budget = 48'(32'(32'(pk) * 32'(pk)) - c2) * 48'(st_reg.peakTime);
    if (tick) begin
      if (sq > c2) begin
        st_next.i2tAcc = (st_reg.i2tAcc > budget) ? st_reg.i2tAcc : 48'(st_reg.i2tAcc + 48'(sq - c2));
      end else begin
        st_next.i2tAcc = (st_reg.i2tAcc > 48'(c2 - sq)) ? 48'(st_reg.i2tAcc - 48'(c2 - sq)) : 48'h0000_0000_0000;
      end
    end
    st_next.restricted = (st_next.i2tAcc >= budget);
    st_next.curLimit = st_next.restricted ? ct : pk;

    // Register writes.
    cfgWr = regWr && regAddr != dpfm_pkg::OFS_CTRL && regAddr != dpfm_pkg::OFS_FAULT &&
            regAddr != dpfm_pkg::OFS_STATUS;
    badVal = regWr && regAddr == dpfm_pkg::OFS_PROT &&
             (regWdata[dpfm_pkg::PR_MTYPE +: 2] > dpfm_pkg::MT_LAST ||
              regWdata[dpfm_pkg::PR_TMODE +: 3] > dpfm_pkg::TM_SW_NC);
    if ((cfgWr && st_reg.run) || badVal) begin
      flt[dpfm_pkg::FB_CFG] = 1'b1;
    end else if (regWr) begin
      case (regAddr)
        dpfm_pkg::OFS_CTRL: st_next.run = regWdata[0];
        dpfm_pkg::OFS_PROT: st_next.prot = regWdata[10:0];
        dpfm_pkg::OFS_TEMPTHR: st_next.tempThr = regWdata[15:0];
        dpfm_pkg::OFS_OVSPD: st_next.ovLim = regWdata;
        dpfm_pkg::OFS_SPDTOL: st_next.spdTol = regWdata;
        dpfm_pkg::OFS_SPDTIME: st_next.spdTime = regWdata[15:0];
        dpfm_pkg::OFS_POSTOL: st_next.posTol = regWdata;
        dpfm_pkg::OFS_POSTIME: st_next.posTime = regWdata[15:0];
        dpfm_pkg::OFS_IPEAK: st_next.iPeak = regWdata[15:0];
        dpfm_pkg::OFS_ICONT: st_next.iCont = regWdata[15:0];
        dpfm_pkg::OFS_PEAKTIME: st_next.peakTime = regWdata[15:0];
        dpfm_pkg::OFS_ENCRES: st_next.encRes = regWdata;
        dpfm_pkg::OFS_ESTEP: st_next.eStep = regWdata[15:0];
        dpfm_pkg::OFS_BRKMAX: st_next.brkMax = regWdata[15:0];
        dpfm_pkg::OFS_FAULT: clr = regWdata[11:0];
        default: st_next.run = st_reg.run;
      endcase
    end

    // Sticky causes; a new event wins over a clear in the same cycle.
    st_next.faults = (st_reg.faults & ~clr) | flt;
    if (|flt) begin
      st_next.run = 1'b0;
    end
    st_next.motorEn = st_next.run && !(|st_next.faults);
    st_next.faultOut = |st_next.faults;

    // Register reads: data stand in the following cycle only.
    st_next.rdata = 32'h0000_0000;
    if (regRd) begin
      case (regAddr)
        dpfm_pkg::OFS_CTRL: st_next.rdata = 32'(st_reg.run);
        dpfm_pkg::OFS_PROT: st_next.rdata = 32'(st_reg.prot);
        dpfm_pkg::OFS_TEMPTHR: st_next.rdata = 32'(st_reg.tempThr);
        dpfm_pkg::OFS_OVSPD: st_next.rdata = st_reg.ovLim;
        dpfm_pkg::OFS_SPDTOL: st_next.rdata = st_reg.spdTol;
        dpfm_pkg::OFS_SPDTIME: st_next.rdata = 32'(st_reg.spdTime);
        dpfm_pkg::OFS_POSTOL: st_next.rdata = st_reg.posTol;
        dpfm_pkg::OFS_POSTIME: st_next.rdata = 32'(st_reg.posTime);
        dpfm_pkg::OFS_IPEAK: st_next.rdata = 32'(st_reg.iPeak);
        dpfm_pkg::OFS_ICONT: st_next.rdata = 32'(st_reg.iCont);
        dpfm_pkg::OFS_PEAKTIME: st_next.rdata = 32'(st_reg.peakTime);
        dpfm_pkg::OFS_ENCRES: st_next.rdata = st_reg.encRes;
        dpfm_pkg::OFS_ESTEP: st_next.rdata = 32'(st_reg.eStep);
        dpfm_pkg::OFS_BRKMAX: st_next.rdata = 32'(st_reg.brkMax);
        dpfm_pkg::OFS_FAULT: st_next.rdata = 32'(st_reg.faults);
        dpfm_pkg::OFS_STATUS: st_next.rdata = {8'h00, st_reg.curLimit, prod[18:16], hall,
                                               st_reg.restricted, st_reg.motorEn};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.iPeak <= dpfm_pkg::IPEAK_RST;
      st_reg.iCont <= dpfm_pkg::ICONT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign regRdata = st_reg.rdata;
  assign motorEnable = st_reg.motorEn;
  assign faultActive = st_reg.faultOut;
  assign currentLimit = st_reg.curLimit;
  assign i2tRestricted = st_reg.restricted;

endmodule

// file: verif/dpfm_monitor_properties.sv
// Purpose: Concurrent checks on the ports of the fault monitor.
// Assumes: Bound to every dpfm_monitor with the same drive ratings.
// Notes: Pin faults pass three sync stages, one agree-filter stage and one detect cycle.
`timescale 1ns/1ps
module dpfm_monitor_checker #(
  parameter logic [15:0] DRIVE_PEAK = 16'h0400,
  parameter logic [15:0] DRIVE_CONT = 16'h0100
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic regWr,
  input wire logic busOverV,
  input wire logic busUnderV,
  input wire logic driveOverTemp,
  input wire logic motorEnable,
  input wire logic faultActive,
  input wire logic [15:0] currentLimit,
  input wire logic i2tRestricted
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  a_fault_stops_motor: assert property (faultActive |-> !motorEnable)
    else $error("motor enabled while a fault is latched");
  a_clear_stays_off: assert property ($fell(faultActive) |-> !motorEnable)
    else $error("motor enabled as faults were cleared");
  a_fault_sticky: assert property (faultActive && !(regWr && regAddr == dpfm_pkg::OFS_FAULT) |=> faultActive)
    else $error("fault dropped without a clear");
  a_bus_over: assert property (busOverV [*8] |=> faultActive && !motorEnable)
    else $error("bus overvoltage not flagged");
  a_bus_under: assert property ($rose(busUnderV) ##1 busUnderV [*7] |-> ##[1:2] faultActive)
    else $error("bus undervoltage not flagged");
  a_drive_hot: assert property (driveOverTemp [*8] |=> faultActive)
    else $error("drive overtemperature not flagged");
  a_limit_clamp: assert property (currentLimit <= DRIVE_PEAK)
    else $error("current limit above drive peak rating");
  a_restrict_cont: assert property (i2tRestricted |-> currentLimit <= DRIVE_CONT)
    else $error("restricted limit above continuous rating");
  c_restricted: cover property ($rose(i2tRestricted));
  c_bus_fault: cover property (busOverV ##1 faultActive);
  c_fault_clear: cover property ($fell(faultActive));
endmodule

bind dpfm_monitor dpfm_monitor_checker #(.DRIVE_PEAK(DRIVE_PEAK), .DRIVE_CONT(DRIVE_CONT)) chk (
  .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWr(regWr), .busOverV(busOverV),
  .busUnderV(busUnderV), .driveOverTemp(driveOverTemp), .motorEnable(motorEnable),
  .faultActive(faultActive), .currentLimit(currentLimit), .i2tRestricted(i2tRestricted));

// file: verif/dpfm_motor_model.sv
// Purpose: Motor side model giving hall and encoder signals.
// Assumes: One step pulse moves one hall sector and one encoder count.
// Notes: badHall[1] forces all hall lines to badHall[0].
`timescale 1ns/1ps
module dpfm_motor_model (
  input wire logic core_clk,
  input wire logic step,
  input wire logic [1:0] badHall,
  output logic [2:0] hallIn,
  output logic encA,
  output logic encB,
  output logic encIndex
);
  localparam logic [17:0] HALL_SEQ = {3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  logic [2:0] sector = 3'h0;
  logic [15:0] cnt = 16'h0000;
  always_ff @(posedge core_clk) begin
    if (step) begin
      sector <= (sector == 3'h5) ? 3'h0 : sector + 3'h1;
      cnt <= cnt + 16'h0001;
    end
  end
  assign hallIn = badHall[1] ? {3{badHall[0]}} : HALL_SEQ[sector * 3 +: 3];
  assign encA = cnt[1];
  assign encB = cnt[1] ^ cnt[0];
  assign encIndex = (cnt[1:0] == 2'h0);
endmodule

// file: verif/dpfm_monitor_tb.sv
// Purpose: Self-checking bench of the fault monitor.
// Assumes: A tick of ten clocks keeps the timed windows short.
// Notes: Expected motor temperature faults come from the small model function tTrip below.
`timescale 1ns/1ps
module dpfm_monitor_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0000_0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic step = 1'b0;
  logic [1:0] badHall = 2'h0;
  logic tempSwitch = 1'b0;
  logic [3:0] pinF = 4'h0;
  logic [11:0] tempAdc = 12'h000;
  logic [31:0] speedAct = 32'h0000_0000, speedCmd = 32'h0000_0000;
  logic [31:0] posAct = 32'h0000_0000, posCmd = 32'h0000_0000;
  logic [15:0] currentMag = 16'h0000;
  logic [31:0] regRdata, f;
  logic [2:0] hallIn;
  logic encA, encB, encIndex, motorEnable, faultActive, i2tRestricted;
  logic [15:0] currentLimit;
  logic [7:0] tolA [3] = '{dpfm_pkg::OFS_OVSPD, dpfm_pkg::OFS_SPDTOL, dpfm_pkg::OFS_POSTOL};
  int errors = 0;
  int totalChecks = 0;
  int m, thr, adc, tol, err, base, n;
  bit sw, ex;

  dpfm_monitor #(.TICK_CYCLES(10)) dut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .hallIn(hallIn),
    .encA(encA), .encB(encB), .encIndex(encIndex), .tempSwitch(tempSwitch), .brakeOn(pinF[0]),
    .busOverV(pinF[1]), .busUnderV(pinF[2]), .driveOverTemp(pinF[3]), .tempAdc(tempAdc),
    .speedAct(speedAct), .speedCmd(speedCmd), .posAct(posAct), .posCmd(posCmd),
    .currentMag(currentMag), .motorEnable(motorEnable), .faultActive(faultActive),
    .currentLimit(currentLimit), .i2tRestricted(i2tRestricted));
  dpfm_motor_model motor (.core_clk(core_clk), .step(step), .badHall(badHall), .hallIn(hallIn),
    .encA(encA), .encB(encB), .encIndex(encIndex));

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic bit tTrip(int md, int th, int ad, bit s);
    case (md)
      0: return (th >= 0) ? (ad > th) : (ad < -th);
      1: return ad < th;
      2: return ad > th;
      3: return s;
      default: return !s;
    endcase
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    d = regRdata;
  endtask
  task automatic clr(input string name);
    wr(dpfm_pkg::OFS_PROT, 32'h0000_0000);
    wr(dpfm_pkg::OFS_FAULT, 32'h0000_0fff);
    $display("test %s finished", name);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'hf04c));
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(dpfm_pkg::OFS_FAULT, f);
    check(f, 32'h0000_0000);
    wr(dpfm_pkg::OFS_OVSPD, 32'h0000_03e8);
    wr(dpfm_pkg::OFS_PROT, 32'h0000_00c0);
    rd(dpfm_pkg::OFS_FAULT, f);
    check(f, 32'h0000_0001);
    rd(8'h40, f);
    check(f, 32'h0000_0000);
    wr(dpfm_pkg::OFS_FAULT, 32'h0000_0fff);
    wr(dpfm_pkg::OFS_CTRL, 32'h0000_0001);
    @(negedge core_clk);
    check(32'(motorEnable), 32'h0000_0001);
    wr(dpfm_pkg::OFS_OVSPD, 32'h0000_0007);
    rd(dpfm_pkg::OFS_FAULT, f);
    check(f, 32'h0000_0001);
    check(32'(motorEnable), 32'h0000_0000);
    rd(dpfm_pkg::OFS_OVSPD, f);
    check(f, 32'h0000_03e8);
    wr(dpfm_pkg::OFS_CTRL, 32'h0000_0000);
    clr("config");
    for (int i = 0; i < 10; i++) begin
      m = i % 5;
      thr = int'($urandom_range(299)) + 1;
      adc = thr + int'($urandom_range(2)) - 1;
      thr = (m == 0 && $urandom_range(1)) ? -thr : thr;
      sw = 1'($urandom_range(1));
      @(posedge core_clk);
      tempAdc <= 12'(adc);
      tempSwitch <= sw;
      wr(dpfm_pkg::OFS_TEMPTHR, 32'(16'(thr)));
      wr(dpfm_pkg::OFS_PROT, 32'h0000_0008 | 32'(m << 8));
      repeat (8) @(posedge core_clk);
      rd(dpfm_pkg::OFS_FAULT, f);
      check(32'(f[4]), 32'(tTrip(m, thr, adc, sw)));
      clr("motor temperature");
    end
    for (int k = 0; k < 3; k++) begin
      for (int c = 0; c < 4; c++) begin
        tol = (c == 1) ? 0 : 10;
        err = (c == 3) ? 10 : 11;
        ex = (c != 2) && (k == 0 || tol != 0) && err > tol;
        err = $urandom_range(1) ? -err : err;
        base = int'($urandom_range(1000));
        wr(tolA[k] + 8'h04, 32'h0000_0002);
        wr(tolA[k], 32'(tol));
        @(posedge core_clk);
        speedCmd <= 32'(base);
        speedAct <= 32'((k == 0) ? err : (k == 1) ? base + err : base);
        posCmd <= 32'(base);
        posAct <= 32'((k == 2) ? base + err : base);
        wr(dpfm_pkg::OFS_PROT, 32'(c != 2) << ((k == 0) ? 4 : 5));
        repeat (60) @(posedge core_clk);
        rd(dpfm_pkg::OFS_FAULT, f);
        check(32'(f[5 + k]), 32'(ex));
        clr("speed and position");
      end
    end
    for (int t = 0; t < 6; t++) begin
      wr(dpfm_pkg::OFS_ENCRES, 32'(4 + (t & 1)));
      wr(dpfm_pkg::OFS_PROT, 32'((t >> 1) << 6) | 32'h0000_0005);
      repeat (3) begin
        step <= 1'b1;
        @(posedge core_clk);
        step <= 1'b0;
        repeat (7) @(posedge core_clk);
      end
      rd(dpfm_pkg::OFS_FAULT, f);
      check(32'(f[1]), 32'h0000_0000);
      check(32'(f[3]), 32'(t & 1));
      @(posedge core_clk);
      badHall <= 2'h2 | 2'(t & 1);
      repeat (8) @(posedge core_clk);
      rd(dpfm_pkg::OFS_FAULT, f);
      check(32'(f[1]), 32'(t < 2));
      @(posedge core_clk);
      badHall <= 2'h0;
      repeat (8) @(posedge core_clk);
      clr("hall");
    end
    wr(dpfm_pkg::OFS_BRKMAX, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      wr(dpfm_pkg::OFS_CTRL, 32'h0000_0001);
      pinF <= 4'(1 << i);
      repeat (60) @(posedge core_clk);
      pinF <= 4'h0;
      repeat (10) @(posedge core_clk);
      rd(dpfm_pkg::OFS_FAULT, f);
      check(f, 32'h0000_0001 << (8 + i));
      check(32'(motorEnable), 32'h0000_0000);
      wr(dpfm_pkg::OFS_CTRL, 32'h0000_0000);
      clr("pin faults");
    end
    wr(dpfm_pkg::OFS_ICONT, 32'h0000_0080);
    wr(dpfm_pkg::OFS_IPEAK, 32'h0000_0800);
    wr(dpfm_pkg::OFS_PEAKTIME, 32'h0000_0002);
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    check(32'(currentLimit), 32'h0000_0400);
    check(32'(i2tRestricted), 32'h0000_0000);
    @(posedge core_clk);
    currentMag <= 16'h0400;
    for (n = 0; n < 500 && i2tRestricted !== 1'b1; n++) @(negedge core_clk);
    if (n == 500) begin
      errors++;
    end
    check(32'(currentLimit), 32'h0000_0080);
    $display("test current limit finished");
    results();
  end
endmodule
